// [bench/nvmcc_array_model.sv]
`timescale 1ns/1ps
// ****************************************
// Array timing model
// ****************************************
// Fixed busy time per start; real arrays are slower, which only widens windows
module nvmcc_array_model
    import nvmcc_pkg::*;
#(
    parameter int LAT = 8
) (
    input  logic         clk,
    input  logic         sys_rst,
    input  nvmcc_start_t start,
    output logic         flash_done,
    output logic         eeprom_done
);
    logic [7:0] fl_cnt_q;
    logic [7:0] ee_cnt_q;

    // Countdown per array, reloaded by each start pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fl_cnt_q <= 8'h00;
            ee_cnt_q <= 8'h00;
        end else begin
            fl_cnt_q <= start.flash ? 8'(LAT) : fl_cnt_q - {7'h00, |fl_cnt_q};
            ee_cnt_q <= start.eeprom ? 8'(LAT) : ee_cnt_q - {7'h00, |ee_cnt_q};
        end
    end

    // One-cycle completion pulses
    assign flash_done  = (fl_cnt_q == 8'h01);
    assign eeprom_done = (ee_cnt_q == 8'h01);
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
// ****************************************
// Command front end bench
// ****************************************
module testbench
    import nvmcc_pkg::*;
;
    localparam int LAT = 8;
    typedef struct packed {
        logic [6:0] code;
        logic       to_ee;
        logic       fl;
        logic       ee;
        nvmcc_err_t err;
    } nvmcc_row_t;
    // Code, store target, expected starts, expected error
    localparam nvmcc_row_t ROWS [17] = '{
        '{7'h02,1'h0,1'h1,1'h0,3'h0}, '{7'h08,1'h0,1'h1,1'h0,3'h0}, '{7'h09,1'h0,1'h1,1'h0,3'h0},
        '{7'h0A,1'h0,1'h1,1'h0,3'h0}, '{7'h0B,1'h0,1'h1,1'h0,3'h0}, '{7'h0C,1'h0,1'h1,1'h0,3'h0},
        '{7'h0D,1'h0,1'h1,1'h0,3'h0}, '{7'h12,1'h1,1'h0,1'h1,3'h0}, '{7'h13,1'h1,1'h0,1'h1,3'h0},
        '{7'h18,1'h1,1'h0,1'h1,3'h0}, '{7'h19,1'h1,1'h0,1'h1,3'h0}, '{7'h1A,1'h1,1'h0,1'h1,3'h0},
        '{7'h1B,1'h1,1'h0,1'h1,3'h0}, '{7'h1C,1'h1,1'h0,1'h1,3'h0}, '{7'h1D,1'h1,1'h0,1'h1,3'h0},
        '{7'h05,1'h0,1'h0,1'h0,3'h1}, '{7'h7F,1'h1,1'h0,1'h0,3'h1}};
    localparam logic [7:0] RST [5] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h01};

    logic         clk, sys_rst, reg_wr, reg_rd, spm_key, io_key, retire, ext_port, in_boot, fuse;
    logic [7:0]   reg_addr, reg_wdata, rdata;
    logic [1:0]   fmap;
    logic         boot_rp, irq, fl_done, ee_done;
    nvmcc_store_t store;
    nvmcc_start_t op_start;
    int           num_errors, n_compared, cycles;

    nvmcc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .unlock_spm_key(spm_key),
        .unlock_ioreg_key(io_key), .insn_retire(retire), .ext_port_access(ext_port),
        .cpu_in_boot(in_boot), .eeprom_preserve_fuse(fuse), .store(store),
        .flash_done(fl_done), .eeprom_done(ee_done), .op_start_q(op_start),
        .flash_map_select_q(fmap), .boot_rp_active_q(boot_rp), .eeprom_ready_irq_q(irq));
    nvmcc_array_model #(.LAT(LAT)) arrays (.clk(clk), .sys_rst(sys_rst), .start(op_start),
        .flash_done(fl_done), .eeprom_done(ee_done));

    // Clock and hang guard; the ceiling is several times the expected run
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus cycles: one-cycle strobes, read data one cycle later only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr    <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd   <= 1'h0;
        #1 cmp("read", e, rdata);
    endtask
    task automatic started(input logic [1:0] e);
        #1 cmp("start", e, {op_start.flash, op_start.eeprom});
    endtask
    task automatic st(input logic ee, input nvmcc_sect_t s, input logic [1:0] e);
        @(posedge clk);
        store <= '{1'h1, ee, s};
        @(posedge clk);
        store.valid <= 1'h0;
        started(e);
    endtask
    task automatic keys();
        @(posedge clk);
        {spm_key, io_key} <= 2'h3;
        @(posedge clk);
        {spm_key, io_key} <= 2'h0;
    endtask
    task automatic summarize();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset, table of commands, then the awkward cases
    initial begin
        {reg_wr, reg_rd, spm_key, io_key, retire, ext_port, in_boot, fuse} = 8'h00;
        {reg_addr, reg_wdata, store} = '0;
        sys_rst = 1'h1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        #1 cmp("map", 9'h003, fmap);
        for (int i = 0; i < 5; i++) rd(8'(i), RST[i]);
        rd(8'h07, 8'h00);
        wr(8'h03, 8'hFE);
        rd(8'h03, 8'h00);
        keys();
        foreach (ROWS[i]) begin
            wr(8'h00, {1'h0, ROWS[i].code});
            rd(8'h00, {1'h0, ROWS[i].code});
            st(ROWS[i].to_ee, SECT_APP_CODE, {ROWS[i].fl, ROWS[i].ee});
            if (ROWS[i].fl | ROWS[i].ee) cmp("cmd", ROWS[i].code, op_start.cmd);
            rd(8'h02, {1'h0, ROWS[i].err, 2'h0, ROWS[i].ee, ROWS[i].fl});
            repeat (LAT + 4) @(posedge clk);
            rd(8'h02, {1'h0, ROWS[i].err, 4'h0});
            wr(8'h02, 8'h00);
            rd(8'h02, 8'h00);
            wr(8'h00, 8'h00);
        end
        // New command while flash busy
        wr(8'h00, 8'h02);
        st(1'h0, SECT_APP_CODE, 2'h2);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h08);
        rd(8'h02, 8'h31);
        rd(8'h00, 8'h00);
        repeat (LAT + 4) @(posedge clk);
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        // Section protection; boot bit refused outside boot
        wr(8'h01, 8'h37);
        rd(8'h01, 8'h35);
        wr(8'h00, 8'h02);
        st(1'h0, SECT_APP_CODE, 2'h0);
        rd(8'h02, 8'h20);
        wr(8'h02, 8'h00);
        st(1'h0, SECT_APP_DATA, 2'h0);
        rd(8'h02, 8'h20);
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h30);
        rd(8'h01, 8'h35);
        @(posedge clk) in_boot <= 1'h1;
        wr(8'h01, 8'h37);
        repeat (2) @(posedge clk);
        #1 cmp("boot_rp", 9'h000, boot_rp);
        @(posedge clk) in_boot <= 1'h0;
        repeat (3) @(posedge clk);
        #1 cmp("boot_rp", 9'h001, boot_rp);
        rd(8'h01, 8'h37);
        // Chip erase: refused from the CPU, EEPROM kept under the fuse
        wr(8'h00, 8'h20);
        started(2'h0);
        rd(8'h02, 8'h10);
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        @(posedge clk) {ext_port, fuse} <= 2'h3;
        wr(8'h00, 8'h20);
        started(2'h2);
        repeat (LAT + 4) @(posedge clk);
        wr(8'h00, 8'h00);
        @(posedge clk) fuse <= 1'h0;
        wr(8'h00, 8'h20);
        started(2'h3);
        @(posedge clk) ext_port <= 1'h0;
        repeat (LAT + 4) @(posedge clk);
        wr(8'h00, 8'h00);
        // Ready interrupt around a self-starting EEPROM erase
        wr(8'h00, 8'h30);
        started(2'h1);
        wr(8'h03, 8'h01);
        #1 cmp("irq", 9'h000, irq);
        repeat (LAT + 4) @(posedge clk);
        #1 cmp("irq", 9'h001, irq);
        rd(8'h04, 8'h01);
        wr(8'h03, 8'h00);
        wr(8'h00, 8'h00);
        // Windows close after four instructions; map stays writable until locked
        repeat (4) begin
            @(posedge clk) retire <= 1'h1;
            @(posedge clk) retire <= 1'h0;
        end
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h00);
        wr(8'h01, 8'h10);
        rd(8'h01, 8'h17);
        keys();
        wr(8'h01, 8'h97);
        wr(8'h01, 8'h27);
        rd(8'h01, 8'h97);
        cmp("map", 9'h001, fmap);
        // Mid-run reset: sticky bits and the map return to their reset values
        @(posedge clk) sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        rd(8'h01, 8'h30);
        cmp("boot_rp", 9'h000, boot_rp);
        summarize();
    end
endmodule

// [common/nvmcc_pkg.sv]
package nvmcc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_COMMAND_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_PROTECTION_MAP   = 8'h01;
    localparam logic [7:0] OFS_BUSY_ERROR       = 8'h02;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h03;
    localparam logic [7:0] OFS_INTERRUPT_FLAG   = 8'h04;

    // ****************************************
    // Command codes
    // ****************************************
    localparam int CMD_W = 7;
    typedef logic [CMD_W-1:0] nvmcc_cmd_t;
    localparam nvmcc_cmd_t CMD_NO_COMMAND   = 7'h00;
    localparam nvmcc_cmd_t CMD_NO_OPERATION = 7'h01;
    localparam nvmcc_cmd_t CMD_FL_WRITE     = 7'h02;
    localparam nvmcc_cmd_t CMD_FL_PAGE      = 7'h08;
    localparam nvmcc_cmd_t CMD_FL_MULTI_LO  = 7'h09;
    localparam nvmcc_cmd_t CMD_FL_MULTI_HI  = 7'h0D;
    localparam nvmcc_cmd_t CMD_EE_WRITE     = 7'h12;
    localparam nvmcc_cmd_t CMD_EE_ERASE_WR  = 7'h13;
    localparam nvmcc_cmd_t CMD_EE_BYTE      = 7'h18;
    localparam nvmcc_cmd_t CMD_EE_MULTI_LO  = 7'h19;
    localparam nvmcc_cmd_t CMD_EE_MULTI_HI  = 7'h1D;
    localparam nvmcc_cmd_t CMD_WHOLE_CHIP   = 7'h20;
    localparam nvmcc_cmd_t CMD_FULL_EEPROM  = 7'h30;

    // ****************************************
    // Error codes and field layout
    // ****************************************
    localparam int ERR_W = 3;
    typedef logic [ERR_W-1:0] nvmcc_err_t;
    localparam nvmcc_err_t ERR_NONE      = 3'h0;
    localparam nvmcc_err_t ERR_BAD_CMD   = 3'h1;
    localparam nvmcc_err_t ERR_PROTECTED = 3'h2;
    localparam nvmcc_err_t ERR_OVERLAP   = 3'h3;

    localparam int         FMAP_W    = 2;
    localparam int         B_LOCK    = 7;
    localparam int         B_FMAP    = 4;
    localparam int         B_DATA_WP = 2;
    localparam int         B_BOOT_RP = 1;
    localparam int         B_CODE_WP = 0;
    localparam int         B_ERR     = 4;
    localparam int         B_EE_BUSY = 1;
    localparam int         B_FL_BUSY = 0;
    localparam int         B_EE_IDLE = 0;
    localparam logic [1:0] FMAP_RST  = 2'h3;

    // Instructions that an unlock key stays valid for
    localparam int UNLOCK_INSNS_DEF = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {SECT_BOOT, SECT_APP_CODE, SECT_APP_DATA} nvmcc_sect_t;

    typedef struct packed {
        logic        valid;
        logic        to_eeprom;
        nvmcc_sect_t sect;
    } nvmcc_store_t;

    typedef struct packed {
        logic       flash;
        logic       eeprom;
        nvmcc_cmd_t cmd;
    } nvmcc_start_t;

endpackage

// [rtl/nvmcc_ctrl.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// Function
// - seven-bit command field sits in command register bits 6:0
// - whole-chip and full-EEPROM erase start on the command write itself
// - other commands only arm; a store to the target memory starts them
// - programming command written while busy records the overlap error
// - flash codes: write 0x02, page erase 0x08, multi-page 0x09..0x0D
// - EEPROM codes: 0x12, 0x13, byte erase 0x18, multi-byte 0x19..0x1D
// - whole-chip erase skips EEPROM under preserve fuse; debug port only
// - unsupported or reserved command reports error code 1
// - write into a protected section reports error code 2
// - error field bits 6:4 holds last error; writing zero clears it
// - status bit 1 EEPROM busy, bit 0 flash busy, read only
// - flash map field writable without the unlock sequence
// - bit 7 locks the flash map field; only reset clears it
// - bit 2 blocks application data updates; only reset clears it
// - bit 0 blocks application code updates; only reset clears it
// - active boot read protection blanks boot reads and fetches
// - boot read protect set only from boot; active after leaving boot
// - interrupt enable bit 0 gives a level request with the idle flag
// - idle flag held while EEPROM not busy; writing one does not clear it
// - protected bits need the unlock key within four instructions
module nvmcc_ctrl
    import nvmcc_pkg::*;
#(
    parameter int UNLOCK_INSNS = UNLOCK_INSNS_DEF
) (
    input  logic               clk,
    input  logic               sys_rst,
    input  logic [7:0]         reg_addr,
    input  logic [7:0]         reg_wdata,
    input  logic               reg_wr,
    input  logic               reg_rd,
    output logic [7:0]         reg_rdata_q,
    input  logic               unlock_spm_key,
    input  logic               unlock_ioreg_key,
    input  logic               insn_retire,
    input  logic               ext_port_access,
    input  logic               cpu_in_boot,
    input  logic               eeprom_preserve_fuse,
    input  nvmcc_store_t       store,
    input  logic               flash_done,
    input  logic               eeprom_done,
    output nvmcc_start_t       op_start_q,
    output logic [FMAP_W-1:0]  flash_map_select_q,
    output logic               boot_rp_active_q,
    output logic               eeprom_ready_irq_q
);

    if (UNLOCK_INSNS < 1 || UNLOCK_INSNS > 15) begin : g_bad_window
        $error("UNLOCK_INSNS must lie in 1..15");
    end

    localparam int WIN_W = $clog2(UNLOCK_INSNS + 1);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(UNLOCK_INSNS);
    localparam logic [WIN_W-1:0] WIN_ONE  = WIN_W'(1);

    // ****************************************
    // Command classes
    // ****************************************
    function automatic logic is_flash_arm(input nvmcc_cmd_t c);
        is_flash_arm = (c == CMD_FL_WRITE) || (c >= CMD_FL_PAGE && c <= CMD_FL_MULTI_HI);
    endfunction

    function automatic logic is_ee_arm(input nvmcc_cmd_t c);
        is_ee_arm = (c == CMD_EE_WRITE) || (c == CMD_EE_ERASE_WR)
                 || (c >= CMD_EE_BYTE && c <= CMD_EE_MULTI_HI);
    endfunction

    function automatic logic is_known(input nvmcc_cmd_t c);
        is_known = c == CMD_NO_COMMAND || c == CMD_NO_OPERATION || is_flash_arm(c)
                || is_ee_arm(c) || c == CMD_WHOLE_CHIP || c == CMD_FULL_EEPROM;
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [WIN_W-1:0] spm_win_q;
    logic [WIN_W-1:0] ioreg_win_q;
    nvmcc_cmd_t       cmd_q;
    nvmcc_cmd_t       cmd_d;
    nvmcc_err_t       err_q;
    logic             err_set;
    nvmcc_err_t       err_code;
    nvmcc_start_t     start_d;
    logic             map_lock_q;
    logic             data_wp_q;
    logic             boot_rp_q;
    logic             code_wp_q;
    logic             irq_en_q;
    logic             ee_idle_q;
    logic             ee_idle_d;
    logic             fl_busy;
    logic             ee_busy;
    logic [7:0]       rd_mux;

    // Address decode
    logic wr_cmd;
    logic wr_prot;
    logic wr_stat;
    logic wr_ien;
    logic wr_iflg;
    logic spm_open;
    logic ioreg_open;
    assign wr_cmd     = reg_wr && reg_addr == OFS_COMMAND_CONTROL;
    assign wr_prot    = reg_wr && reg_addr == OFS_PROTECTION_MAP;
    assign wr_stat    = reg_wr && reg_addr == OFS_BUSY_ERROR;
    assign wr_ien     = reg_wr && reg_addr == OFS_INTERRUPT_ENABLE;
    assign wr_iflg    = reg_wr && reg_addr == OFS_INTERRUPT_FLAG;
    assign spm_open   = spm_win_q != '0;
    assign ioreg_open = ioreg_win_q != '0;

    // ****************************************
    // Unlock windows
    // ****************************************
    // Each key opens its own window; retired instructions close it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spm_win_q   <= '0;
            ioreg_win_q <= '0;
        end else begin
            if (unlock_spm_key) begin
                spm_win_q <= WIN_LOAD;
            end else if (insn_retire && spm_open) begin
                spm_win_q <= spm_win_q - WIN_ONE;
            end
            if (unlock_ioreg_key) begin
                ioreg_win_q <= WIN_LOAD;
            end else if (insn_retire && ioreg_open) begin
                ioreg_win_q <= ioreg_win_q - WIN_ONE;
            end
        end
    end

    // ****************************************
    // Command decode and store handling
    // ****************************************
    // A store is judged before a command write in the same cycle,
    // the store still uses the command that was armed before it
    always_comb begin
        cmd_d    = cmd_q;
        err_set  = 1'b0;
        err_code = ERR_NONE;
        start_d  = '{flash: 1'b0, eeprom: 1'b0, cmd: cmd_q};
        // Store against the armed command
        if (store.valid) begin
            if (!is_known(cmd_q)) begin
                err_set  = 1'b1;
                err_code = ERR_BAD_CMD;
            end else if (is_flash_arm(cmd_q) && !store.to_eeprom) begin
                if (fl_busy) begin
                    err_set  = 1'b1;
                    err_code = ERR_OVERLAP;
                end else if ((code_wp_q && store.sect == SECT_APP_CODE)
                          || (data_wp_q && store.sect == SECT_APP_DATA)) begin
                    err_set  = 1'b1;
                    err_code = ERR_PROTECTED;
                end else begin
                    start_d.flash = 1'b1;
                end
            end else if (is_ee_arm(cmd_q) && store.to_eeprom) begin
                if (ee_busy) begin
                    err_set  = 1'b1;
                    err_code = ERR_OVERLAP;
                end else begin
                    start_d.eeprom = 1'b1;
                end
            end
        end
        // Command write, only inside the unlock window
        if (wr_cmd && spm_open) begin
            if (reg_wdata[CMD_W-1:0] != CMD_NO_COMMAND
                && reg_wdata[CMD_W-1:0] != CMD_NO_OPERATION
                && (fl_busy || ee_busy)) begin
                err_set  = 1'b1;
                err_code = ERR_OVERLAP;
            end else begin
                cmd_d = reg_wdata[CMD_W-1:0];
                if (!is_known(cmd_d)
                    || (cmd_d == CMD_WHOLE_CHIP && !ext_port_access)) begin
                    err_set  = 1'b1;
                    err_code = ERR_BAD_CMD;
                end else if (cmd_d == CMD_WHOLE_CHIP) begin
                    start_d = '{flash: 1'b1, eeprom: !eeprom_preserve_fuse,
                                cmd: cmd_d};
                end else if (cmd_d == CMD_FULL_EEPROM) begin
                    start_d = '{flash: 1'b0, eeprom: 1'b1, cmd: cmd_d};
                end
            end
        end
    end

    // Command register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_q <= CMD_NO_COMMAND;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // Start pulses toward the array sequencers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_start_q <= '0;
        end else begin
            op_start_q <= start_d;
        end
    end

    // ****************************************
    // Busy trackers
    // ****************************************
    nvmcc_op_track u_flash_track (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (start_d.flash),
        .done    (flash_done),
        .busy_q  (fl_busy)
    );

    nvmcc_op_track u_eeprom_track (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (start_d.eeprom),
        .done    (eeprom_done),
        .busy_q  (ee_busy)
    );

    // ****************************************
    // Error field
    // ****************************************
    // New error wins over a clearing write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            err_q <= ERR_NONE;
        end else if (err_set) begin
            err_q <= err_code;
        end else if (wr_stat && reg_wdata[B_ERR +: ERR_W] == ERR_NONE) begin
            err_q <= ERR_NONE;
        end
    end

    // ****************************************
    // Protection and mapping
    // ****************************************
    // Map field is open to plain writes until locked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flash_map_select_q <= FMAP_RST;
        end else if (wr_prot && !map_lock_q) begin
            flash_map_select_q <= reg_wdata[B_FMAP +: FMAP_W];
        end
    end

    // Sticky protection bits; only reset returns them to zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            map_lock_q <= 1'b0;
            data_wp_q  <= 1'b0;
            code_wp_q  <= 1'b0;
            boot_rp_q  <= 1'b0;
        end else if (wr_prot && ioreg_open) begin
            map_lock_q <= map_lock_q | reg_wdata[B_LOCK];
            data_wp_q  <= data_wp_q | reg_wdata[B_DATA_WP];
            code_wp_q  <= code_wp_q | reg_wdata[B_CODE_WP];
            boot_rp_q  <= boot_rp_q | (reg_wdata[B_BOOT_RP] && cpu_in_boot);
        end
    end

    // Blanking starts only once code has left the boot section
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_rp_active_q <= 1'b0;
        end else if (boot_rp_q && !cpu_in_boot) begin
            boot_rp_active_q <= 1'b1;
        end
    end

    // ****************************************
    // EEPROM ready flag and request
    // ****************************************
    // Idle keeps the flag set; a starting operation takes it down
    always_comb begin
        if (start_d.eeprom) begin
            ee_idle_d = 1'b0;
        end else begin
            ee_idle_d = !ee_busy || (ee_idle_q && !(wr_iflg && reg_wdata[B_EE_IDLE]));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ee_idle_q <= 1'b0;
        end else begin
            ee_idle_q <= ee_idle_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_en_q <= 1'b0;
        end else if (wr_ien) begin
            irq_en_q <= reg_wdata[B_EE_IDLE];
        end
    end

    // Level request, one register stage behind the flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eeprom_ready_irq_q <= 1'b0;
        end else begin
            eeprom_ready_irq_q <= irq_en_q && ee_idle_q;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Unused positions and unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            OFS_COMMAND_CONTROL: begin
                rd_mux[CMD_W-1:0] = cmd_q;
            end
            OFS_PROTECTION_MAP: begin
                rd_mux[B_LOCK]             = map_lock_q;
                rd_mux[B_FMAP +: FMAP_W]   = flash_map_select_q;
                rd_mux[B_DATA_WP]          = data_wp_q;
                rd_mux[B_BOOT_RP]          = boot_rp_q;
                rd_mux[B_CODE_WP]          = code_wp_q;
            end
            OFS_BUSY_ERROR: begin
                rd_mux[B_ERR +: ERR_W] = err_q;
                rd_mux[B_EE_BUSY]      = ee_busy;
                rd_mux[B_FL_BUSY]      = fl_busy;
            end
            OFS_INTERRUPT_ENABLE: begin
                rd_mux[B_EE_IDLE] = irq_en_q;
            end
            OFS_INTERRUPT_FLAG: begin
                rd_mux[B_EE_IDLE] = ee_idle_q;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_self_start_ee: assert property (
        wr_cmd && spm_open && reg_wdata[CMD_W-1:0] == CMD_FULL_EEPROM && !fl_busy
        && !ee_busy |=> op_start_q.eeprom ##1 ee_busy)
        else $error("full EEPROM erase did not start at once");

    a_arm_only: assert property (
        wr_cmd && spm_open && is_flash_arm(reg_wdata[CMD_W-1:0]) && !store.valid
        |=> !op_start_q.flash && !op_start_q.eeprom)
        else $error("arming command started an operation");

    a_overlap_code: assert property (
        wr_cmd && spm_open && reg_wdata[CMD_W-1:0] > CMD_NO_OPERATION
        && (fl_busy || ee_busy) |=> err_q == ERR_OVERLAP && $stable(cmd_q))
        else $error("overlap error not recorded");

    a_chip_ext_only: assert property (
        wr_cmd && spm_open && reg_wdata[CMD_W-1:0] == CMD_WHOLE_CHIP
        && !ext_port_access |=> !op_start_q.flash && err_q == ERR_BAD_CMD)
        else $error("whole-chip erase accepted from the CPU");

    a_bad_code: assert property (
        wr_cmd && spm_open && !fl_busy && !ee_busy
        && !is_known(reg_wdata[CMD_W-1:0]) |=> err_q == ERR_BAD_CMD)
        else $error("reserved command not flagged");

    a_protect_code: assert property (
        store.valid && !wr_cmd && is_flash_arm(cmd_q) && !store.to_eeprom && !fl_busy
        && code_wp_q && store.sect == SECT_APP_CODE
        |=> err_q == ERR_PROTECTED && !op_start_q.flash)
        else $error("write into protected code section went ahead");

    a_busy_readback: assert property (
        reg_rd && reg_addr == OFS_BUSY_ERROR
        |=> reg_rdata_q[B_FL_BUSY] == $past(fl_busy) && reg_rdata_q[7] == 1'b0)
        else $error("busy status read back wrong");

    a_map_frozen: assert property (
        map_lock_q |=> map_lock_q && $stable(flash_map_select_q))
        else $error("locked flash map changed");

    a_wp_sticky: assert property (
        data_wp_q && code_wp_q |=> data_wp_q && code_wp_q)
        else $error("write protection dropped without reset");

    a_boot_rp_src: assert property (
        !boot_rp_q && wr_prot && !cpu_in_boot |=> !boot_rp_q)
        else $error("boot read protect set from outside boot");

    a_irq_level: assert property (
        1'b1 |=> eeprom_ready_irq_q == $past(irq_en_q && ee_idle_q))
        else $error("ready request does not follow enable and flag");

    a_idle_held: assert property (
        !ee_busy && !start_d.eeprom |=> ee_idle_q)
        else $error("idle flag not held while EEPROM idle");

    a_cmd_locked: assert property (
        !spm_open |=> $stable(cmd_q))
        else $error("command changed without unlock");

endmodule

// [rtl/nvmcc_op_track.sv]
`timescale 1ns/1ps
// Busy tracker for one memory array
module nvmcc_op_track (
    input  logic clk,
    input  logic sys_rst,
    input  logic start,
    input  logic done,
    output logic busy_q
);

    // ****************************************
    // Busy level
    // ****************************************
    // Start wins over done so a back-to-back operation is not lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
        end else if (done) begin
            busy_q <= 1'b0;
        end
    end

    a_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
        start |=> busy_q)
        else $error("busy did not rise after start");

endmodule
